// ==== verilog/spwm_top.sv ====
// standard 10-bit pwm with 8-bit period timer, registers on a plain port
`timescale 1ns/10ps
`default_nettype none
`include "spwm_params.svh"

module spwm_top (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_sleep,
  input wire logic [`SPWM_ADDR_W-1:0] i_addr,
  input wire logic [`SPWM_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`SPWM_DATA_W-1:0] o_rdata,
  output logic o_pwm_pin_out,
  output logic o_pwm_pin_oe_n,
  output logic o_period_match_flag
);
  spwm_pkg::spwm_top_state_t st;
  spwm_pkg::spwm_top_state_t next_st;
  spwm_pkg::spwm_timebase_t tb;

  logic [9:0] duty_active;
  logic [9:0] duty_next;
  logic [7:0] duty_shadow;
  logic [9:0] time_base;
  logic [9:0] time_base_inc;
  logic pwm_active;
  logic unit_off;
  logic run;
  logic clear_pre;
  logic rollover;
  logic duty_hit;
  logic wr_ok;
  logic wr_shadow;
  logic flag_clear;
  logic post_hit;

  // true when a write lands on the given register
  function automatic logic wr_to(
    input logic wr,
    input logic [`SPWM_ADDR_W-1:0] addr,
    input logic [`SPWM_ADDR_W-1:0] target
  );
    wr_to = wr && (addr == target);
  endfunction

  // mode 11xx selects pwm; 0000 holds the unit in reset
  function automatic logic is_pwm(input logic [3:0] mode);
    is_pwm = (mode[3:2] == `SPWM_MODE_PWM_TOP);
  endfunction

  // sleep freezes everything but the read port, software writes included
  assign wr_ok = i_wr && !i_sleep;

  assign pwm_active = is_pwm(st.unit_ctrl.unit_mode_select);
  assign unit_off = (st.unit_ctrl.unit_mode_select == `SPWM_MODE_OFF);

  // period timer runs from the system clock only; no other source
  assign run = st.timer_ctrl.period_timer_on && !i_sleep;

  // a write to the counter or the timer control restarts the prescaler
  assign clear_pre = wr_to(wr_ok, i_addr, `SPWM_A_TIMER_COUNT)
    || wr_to(wr_ok, i_addr, `SPWM_A_TIMER_CTRL);

  spwm_prescaler u_pre (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_run(run),
    .i_clear(clear_pre),
    .i_prescale_select(st.timer_ctrl.prescale_select),
    .o_tb(tb)
  );

  // shadow writable only outside pwm mode
  assign wr_shadow = wr_to(wr_ok, i_addr, `SPWM_A_DUTY_SHADOW)
    && !pwm_active;

  // counter equal to limit: this increment wraps and opens a new period
  assign rollover = tb.tick
    && (st.period_counter == st.period_limit);

  spwm_duty_buffer u_buf (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_unit_off(unit_off),
    .i_load(rollover),
    .i_sw_write(wr_shadow),
    .i_sw_data(i_wdata),
    .i_duty_upper(st.duty_upper),
    .i_duty_low_bits(st.unit_ctrl.duty_low_bits),
    .o_duty_active(duty_active),
    .o_duty_next(duty_next),
    .o_duty_shadow(duty_shadow)
  );

  // 10-bit time base: counter with two low phase bits
  assign time_base = {st.period_counter, tb.phase};

  // compare against the value the base takes at this edge, so the pin
  // falls exactly duty x prescale cycles after it rose
  assign time_base_inc = time_base + 10'h001;
  assign duty_hit = tb.step && (time_base_inc == duty_active);

  assign flag_clear = wr_to(wr_ok, i_addr, `SPWM_A_STATUS)
    && i_wdata[`SPWM_FLAG_BIT];

  // postscaler only paces the flag, never the period
  assign post_hit = (st.post_cnt == st.timer_ctrl.postscale_select);

  always_comb begin
    next_st = st;

    // register writes
    if (wr_to(wr_ok, i_addr, `SPWM_A_UNIT_CTRL)) begin
      next_st.unit_ctrl.duty_low_bits = i_wdata[5:4];
      next_st.unit_ctrl.unit_mode_select = i_wdata[3:0];
    end
    if (wr_to(wr_ok, i_addr, `SPWM_A_DUTY_UPPER)) begin
      next_st.duty_upper = i_wdata;
    end
    if (wr_to(wr_ok, i_addr, `SPWM_A_PERIOD_LIMIT)) begin
      next_st.period_limit = i_wdata;
    end
    if (wr_to(wr_ok, i_addr, `SPWM_A_TIMER_CTRL)) begin
      next_st.timer_ctrl.postscale_select = i_wdata[6:3];
      next_st.timer_ctrl.period_timer_on = i_wdata[2];
      next_st.timer_ctrl.prescale_select = i_wdata[1:0];
      next_st.post_cnt = 4'h0;
    end
    if (wr_to(wr_ok, i_addr, `SPWM_A_PIN_DIR)) begin
      next_st.pin_direction = i_wdata[`SPWM_DIR_BIT];
    end

    // period counter: software load wins over counting
    if (wr_to(wr_ok, i_addr, `SPWM_A_TIMER_COUNT)) begin
      next_st.period_counter = i_wdata;
    end else if (rollover) begin
      next_st.period_counter = 8'h00;
    end else if (tb.tick) begin
      next_st.period_counter = st.period_counter + 8'h01;
    end

    // match flag through the postscaler; a set beats a same-cycle clear
    if (rollover && !wr_to(wr_ok, i_addr, `SPWM_A_TIMER_CTRL)) begin
      next_st.post_cnt = post_hit ? 4'h0 : st.post_cnt + 4'h1;
    end
    if (flag_clear) begin
      next_st.period_match_flag = 1'b0;
    end
    if (rollover && post_hit) begin
      next_st.period_match_flag = 1'b1;
    end

    // pin latch
    if (unit_off || !pwm_active) begin
      next_st.pin_latch = 1'b0;
    end else if (rollover) begin
      // zero duty never raises the pin
      next_st.pin_latch = (duty_next != `SPWM_DUTY_ZERO);
    end else if (duty_hit) begin
      // unreached when duty exceeds the period: level holds
      next_st.pin_latch = 1'b0;
    end

    // pin driven only in pwm mode with the direction bit cleared
    next_st.pin_oe_n = !(is_pwm(next_st.unit_ctrl.unit_mode_select)
      && !next_st.pin_direction);

    // read port: data stand in the cycle after the strobe
    next_st.rdata = `SPWM_RST_BYTE;
    if (i_rd) begin
      case (i_addr)
        `SPWM_A_UNIT_CTRL: begin
          next_st.rdata = st.unit_ctrl;
        end
        `SPWM_A_DUTY_UPPER: begin
          next_st.rdata = st.duty_upper;
        end
        `SPWM_A_DUTY_SHADOW: begin
          next_st.rdata = duty_shadow;
        end
        `SPWM_A_PERIOD_LIMIT: begin
          next_st.rdata = st.period_limit;
        end
        `SPWM_A_TIMER_CTRL: begin
          next_st.rdata = st.timer_ctrl;
        end
        `SPWM_A_TIMER_COUNT: begin
          next_st.rdata = st.period_counter;
        end
        `SPWM_A_STATUS: begin
          next_st.rdata = {7'h00, st.period_match_flag};
        end
        `SPWM_A_PIN_DIR: begin
          next_st.rdata = {7'h00, st.pin_direction};
        end
        default: begin
          next_st.rdata = `SPWM_RST_BYTE;
        end
      endcase
    end

    // in sleep, only the read port moves
    if (i_sleep) begin
      next_st.pin_latch = st.pin_latch;
      next_st.period_match_flag = st.period_match_flag;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= '0;
      st.pin_direction <= `SPWM_RST_DIR;
      st.pin_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_pwm_pin_out = st.pin_latch;
  assign o_pwm_pin_oe_n = st.pin_oe_n;
  assign o_period_match_flag = st.period_match_flag;

  // resolution: log2(4 x (limit+1)) bits of the 10-bit duty are usable,
  // all ten only with limit at its top value
endmodule
`default_nettype wire

// ==== pkg/spwm_params.svh ====
// constants: register map, field positions, reset values, mode codes
`ifndef SPWM_PARAMS_SVH
`define SPWM_PARAMS_SVH

`define SPWM_ADDR_W 4
`define SPWM_DATA_W 8
`define SPWM_A_UNIT_CTRL 4'h0
`define SPWM_A_DUTY_UPPER 4'h1
`define SPWM_A_DUTY_SHADOW 4'h2
`define SPWM_A_PERIOD_LIMIT 4'h3
`define SPWM_A_TIMER_CTRL 4'h4
`define SPWM_A_TIMER_COUNT 4'h5
`define SPWM_A_STATUS 4'h6
`define SPWM_A_PIN_DIR 4'h7

`define SPWM_RST_BYTE 8'h00
`define SPWM_RST_DIR 1'h1
`define SPWM_MODE_OFF 4'h0
`define SPWM_MODE_PWM_TOP 2'h3
`define SPWM_FLAG_BIT 0
`define SPWM_DIR_BIT 0

`define SPWM_PS_1 2'h0
`define SPWM_PS_4 2'h1
`define SPWM_PRE_MAX_1 6'h03
`define SPWM_PRE_MAX_4 6'h0F
`define SPWM_PRE_MAX_16 6'h3F
`define SPWM_PHASE_LAST 2'h3
`define SPWM_DUTY_ZERO 10'h000

`endif

// ==== pkg/spwm_pkg.sv ====
// types shared by the pwm unit and its helpers
package spwm_pkg;
  typedef struct packed {
    logic [1:0] pad;
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_select;
  } spwm_unit_ctrl_t;

  typedef struct packed {
    logic pad;
    logic [3:0] postscale_select;
    logic period_timer_on;
    logic [1:0] prescale_select;
  } spwm_timer_ctrl_t;

  typedef struct packed {
    logic step;
    logic tick;
    logic [1:0] phase;
  } spwm_timebase_t;

  typedef struct packed {
    logic [5:0] cnt;
  } spwm_pre_state_t;

  typedef struct packed {
    logic [7:0] duty_shadow;
    logic [1:0] low_latch;
  } spwm_buf_state_t;

  typedef struct packed {
    spwm_unit_ctrl_t unit_ctrl;
    logic [7:0] duty_upper;
    logic [7:0] period_limit;
    spwm_timer_ctrl_t timer_ctrl;
    logic [7:0] period_counter;
    logic [3:0] post_cnt;
    logic period_match_flag;
    logic pin_direction;
    logic pin_latch;
    logic pin_oe_n;
    logic [7:0] rdata;
  } spwm_top_state_t;
endpackage

// ==== verilog/spwm_prescaler.sv ====
// period timer prescaler: step and rollover strobes plus low time base bits
`timescale 1ns/10ps
`default_nettype none
`include "spwm_params.svh"

module spwm_prescaler (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic i_clear,
  input wire logic [1:0] i_prescale_select,
  output spwm_pkg::spwm_timebase_t o_tb
);
  spwm_pkg::spwm_pre_state_t st;
  spwm_pkg::spwm_pre_state_t next_st;
  logic [5:0] last;
  logic [1:0] phase;
  logic step;

  // the 2 extra base bits: clock phase at 1:1, prescaler bits otherwise
  always_comb begin
    case (i_prescale_select)
      `SPWM_PS_1: begin
        last = `SPWM_PRE_MAX_1;
        phase = st.cnt[1:0];
        step = 1'b1;
      end
      `SPWM_PS_4: begin
        last = `SPWM_PRE_MAX_4;
        phase = st.cnt[3:2];
        step = (st.cnt[1:0] == `SPWM_PHASE_LAST);
      end
      default: begin
        last = `SPWM_PRE_MAX_16;
        phase = st.cnt[5:4];
        step = (st.cnt[3:0] == 4'hF);
      end
    endcase
    next_st = st;
    if (i_clear) begin
      next_st.cnt = 6'h00;
    end else if (i_run) begin
      next_st.cnt = (st.cnt == last) ? 6'h00 : st.cnt + 6'h01;
    end
    o_tb.phase = phase;
    o_tb.step = i_run && !i_clear && step;
    o_tb.tick = i_run && !i_clear && (st.cnt == last);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/spwm_duty_buffer.sv ====
// duty double buffer: shadow byte plus hidden 2-bit latch
`timescale 1ns/10ps
`default_nettype none
`include "spwm_params.svh"

module spwm_duty_buffer (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_unit_off,
  input wire logic i_load,
  input wire logic i_sw_write,
  input wire logic [7:0] i_sw_data,
  input wire logic [7:0] i_duty_upper,
  input wire logic [1:0] i_duty_low_bits,
  output logic [9:0] o_duty_active,
  output logic [9:0] o_duty_next,
  output logic [7:0] o_duty_shadow
);
  spwm_pkg::spwm_buf_state_t st;
  spwm_pkg::spwm_buf_state_t next_st;

  always_comb begin
    next_st = st;
    o_duty_next = {i_duty_upper, i_duty_low_bits};
    if (i_unit_off) begin
      next_st = '0;
    end else if (i_load) begin
      next_st.duty_shadow = i_duty_upper;
      next_st.low_latch = i_duty_low_bits;
    end else if (i_sw_write) begin
      next_st.duty_shadow = i_sw_data;
    end
    o_duty_active = {st.duty_shadow, st.low_latch};
    o_duty_shadow = st.duty_shadow;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule
`default_nettype wire

// ==== verif/spwm_top_sva.sv ====
// port assertions for the pwm unit, bound onto the top module
`timescale 1ns/10ps
`default_nettype none
`include "spwm_params.svh"
module spwm_top_sva (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_sleep,
  input wire logic [`SPWM_ADDR_W-1:0] i_addr,
  input wire logic [`SPWM_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [`SPWM_DATA_W-1:0] o_rdata,
  input wire logic o_pwm_pin_out,
  input wire logic o_pwm_pin_oe_n,
  input wire logic o_period_match_flag
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic post_zero;
  // flag tracks every rollover only while the postscaler divides by one
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      post_zero <= 1'b1;
    end else if (i_wr && !i_sleep && i_addr == 4'h4) begin
      post_zero <= (i_wdata[6:3] == 4'h0);
    end
  end
  a_reset_defaults: assert property (disable iff (1'b0) i_reset |=> o_pwm_pin_oe_n &&
    !o_pwm_pin_out && !o_period_match_flag && o_rdata == 8'h00) else $error("not reset");
  a_status_read: assert property (i_rd && i_addr == 4'h6 |=>
    o_rdata == {7'h00, $past(o_period_match_flag)}) else $error("status read wrong");
  a_flag_rise: assert property ($rose(o_pwm_pin_out) && post_zero |->
    o_period_match_flag) else $error("flag missing at rollover");
  a_period_min: assert property ($rose(o_pwm_pin_out) |=>
    !$rose(o_pwm_pin_out) [*3]) else $error("period too short");
  a_sleep_hold: assert property (i_sleep |=> $stable(o_pwm_pin_out) &&
    $stable(o_pwm_pin_oe_n) && $stable(o_period_match_flag)) else $error("sleep moved");
  a_sleep_count: assert property (i_sleep && i_rd && i_addr == 4'h5 ##2 i_sleep && i_rd &&
    i_addr == 4'h5 |=> o_rdata == $past(o_rdata, 2)) else $error("counter moved in sleep");
  a_pin_release: assert property (i_wr && !i_sleep && (i_addr == 4'h0 && i_wdata == 8'h00 ||
    i_addr == 4'h7 && i_wdata[0]) |=> o_pwm_pin_oe_n) else $error("pin still driven");
  a_mode_off_low: assert property (i_wr && !i_sleep && i_addr == 4'h0 && i_wdata[3:0] == 4'h0
    ##1 !(i_wr && i_addr == 4'h0) && !i_sleep |=> !o_pwm_pin_out) else $error("pin latch kept");
  c_pulse: cover property ($fell(o_pwm_pin_out) && !o_pwm_pin_oe_n);
  c_wake: cover property ($fell(i_sleep));
  c_flag_clear: cover property ($fell(o_period_match_flag));
endmodule
bind spwm_top spwm_top_sva u_spwm_top_sva (.i_clk(i_clk), .i_reset(i_reset), .i_sleep(i_sleep),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_pwm_pin_out(o_pwm_pin_out), .o_pwm_pin_oe_n(o_pwm_pin_oe_n),
  .o_period_match_flag(o_period_match_flag));
`default_nettype wire

// ==== verif/spwm_load_model.sv ====
// load on the pwm pin: measures one whole period and its high time
`timescale 1ns/10ps
`default_nettype none
module spwm_load_model (
  input wire logic i_clk,
  input wire logic i_pin,
  input wire logic i_oe_n,
  input wire logic i_arm,
  output logic o_valid,
  output logic [15:0] o_high,
  output logic [15:0] o_period
);
  logic prev = 1'b0;
  logic [1:0] st = 2'h2;
  logic [15:0] cnt = 16'h0000;
  logic [15:0] hi = 16'h0000;
  // pull-down: a released line reads low
  wire logic lvl = !i_oe_n && i_pin;
  // first rise after arming only starts timing, a partial period is never reported
  always @(posedge i_clk) begin
    o_valid <= 1'b0;
    prev <= lvl;
    if (i_arm) begin
      st <= 2'h0;
    end else if (lvl && !prev) begin
      o_valid <= (st == 2'h1);
      o_high <= hi;
      o_period <= cnt;
      st <= (st == 2'h2) ? st : st + 2'h1;
      cnt <= 16'h0001;
      hi <= 16'h0001;
    end else begin
      cnt <= cnt + 16'h0001;
      hi <= hi + {15'h0000, lvl};
    end
  end
endmodule
`default_nettype wire

// ==== verif/spwm_top_tb_top.sv ====
// self-checking bench for the pwm unit with a pin load model
`timescale 1ns/10ps
`default_nettype none
module spwm_top_tb_top;
  logic i_clk;
  logic i_reset = 1'b1;
  logic i_sleep = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic m_arm = 1'b0;
  logic rd_seen = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic o_pwm_pin_out, o_pwm_pin_oe_n, o_period_match_flag, m_valid;
  logic [15:0] m_high, m_period;
  logic [7:0] exp_q[$];
  logic [31:0] meas_q[$];
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int l, d, ps;
  spwm_top u_spwm_top (.i_clk(i_clk), .i_reset(i_reset), .i_sleep(i_sleep), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_pwm_pin_out(o_pwm_pin_out), .o_pwm_pin_oe_n(o_pwm_pin_oe_n),
    .o_period_match_flag(o_period_match_flag));
  spwm_load_model u_spwm_load_model (.i_clk(i_clk), .i_pin(o_pwm_pin_out),
    .i_oe_n(o_pwm_pin_oe_n), .i_arm(m_arm), .o_valid(m_valid), .o_high(m_high),
    .o_period(m_period));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one idle cycle after each strobe keeps a strobe from being driven twice in a step
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic pulse(input logic [31:0] e);
    meas_q.push_back(e);
    m_arm <= 1'b1;
    @(posedge i_clk);
    m_arm <= 1'b0;
    for (int i = 0; i < 5000 && meas_q.size() > 0; i++) @(posedge i_clk);
  endtask
  always @(posedge i_clk) begin
    if (rd_seen) chk({24'h0, o_rdata}, {24'h0, exp_q.pop_front()});
    if (m_valid) chk({m_high, m_period}, meas_q.pop_front());
    rd_seen <= i_rd;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(59479));
    repeat (16) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    for (int a = 0; a < 10; a++) rd(4'(a), (a == 7) ? 8'h01 : 8'h00);
    for (int p = 0; p < 3; p++) begin
      l = $urandom_range(5, 1);
      d = $urandom_range(4 * (l + 1) - 1, 1);
      ps = (p == 0) ? 1 : (p == 1) ? 4 : 16;
      wr(4'h7, 8'h01);
      wr(4'h3, 8'(l));
      // a running count above the new limit would first wrap through 255
      wr(4'h5, 8'h00);
      wr(4'h0, {2'h0, 2'(d), 2'h3, 2'(p)});
      wr(4'h1, 8'(d >> 2));
      wr(4'h6, 8'h01);
      wr(4'h4, {1'b0, 4'(p * 5), 1'b1, 2'(p)});
      wr(4'h7, 8'h00);
      // sleeping before the measurement checks the period and high time measured after waking
      i_sleep <= 1'b1;
      repeat (40) @(posedge i_clk);
      i_sleep <= 1'b0;
      pulse({16'(d * ps), 16'((l + 1) * 4 * ps)});
      wr(4'h2, 8'(~d));
      rd(4'h2, 8'(d >> 2));
      rd(4'h0, {2'h0, 2'(d), 2'h3, 2'(p)});
    end
    wr(4'h3, 8'h01);
    wr(4'h4, 8'h04);
    wr(4'h5, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr(4'h1, k ? 8'hFF : 8'h00);
      wr(4'h0, k ? 8'h3F : 8'h0F);
      repeat (20) @(posedge i_clk);
      repeat (16) begin
        @(posedge i_clk);
        chk({31'h0, o_pwm_pin_out}, 32'(k));
      end
    end
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h2A);
    rd(4'h6, 8'h01);
    chk({31'h0, o_period_match_flag}, 32'h1);
    wr(4'h6, 8'h01);
    rd(4'h6, 8'h00);
    // timer is running when sleep starts, two edges before its first tick
    wr(4'h4, 8'h04);
    i_sleep <= 1'b1;
    wr(4'h5, 8'h55);
    rd(4'h5, 8'h2A);
    rd(4'h5, 8'h2A);
    i_sleep <= 1'b0;
    wr(4'h0, 8'h00);
    chk({31'h0, o_pwm_pin_oe_n}, 32'h1);
    rd(4'h2, 8'h00);
    // mode off holds the buffer cleared; a compare mode leaves it writable
    wr(4'h0, 8'h08);
    wr(4'h2, 8'h5A);
    rd(4'h2, 8'h5A);
    repeat (4) @(posedge i_clk);
    chk(32'(meas_q.size()), 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
